// ==== design/bmt_top.sv ====
/*
  I2C slave with configuration and result registers and single-shot trigger.
  Assumes scl/sda are asynchronous pins, an open-drain wire resolved outside.
*/
module bmt_top #(
  parameter int CYC3 = bmt_pkg::CYC_508,
  parameter int CYCB = bmt_pkg::CYC_BASE
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [1:0]  addr_sel,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic [15:0] sample_bus,
  input  wire logic [15:0] sample_shunt,
  output logic [15:0]      config_word,
  output logic             conv_start,
  output logic             conv_busy,
  output logic             result_ready
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_ADDR = 7'h02, ST_ACK = 7'h04, ST_RX = 7'h08,
    ST_TX = 7'h10, ST_TXACK = 7'h20, ST_SKIP = 7'h40
  } bmt_state_t;
  typedef enum logic [2:0] {
    CS_IDLE = 3'h1, CS_SHUNT = 3'h2, CS_BUS = 3'h4
  } bmt_conv_t;

  logic rst_s1_q, rst_s2_q, rst_n;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // Pin synchronisers, then a third stage for edge detection
  logic [2:0] scl_q, sda_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
    end
  end
  logic scl_r, scl_f, start_c, stop_c;
  assign scl_r   = scl_q[1] & ~scl_q[2];
  assign scl_f   = ~scl_q[1] & scl_q[2];
  assign start_c = scl_q[2] & scl_q[1] & sda_q[2] & ~sda_q[1];
  assign stop_c  = scl_q[2] & scl_q[1] & ~sda_q[2] & sda_q[1];

  bmt_state_t  st_q, st_d;
  logic [7:0]  sh_q, sh_d;
  logic [3:0]  bit_q, bit_d;
  logic [1:0]  byte_q, byte_d;
  logic        rw_q, rw_d;
  logic [7:0]  ptr_q, ptr_d;
  logic [7:0]  hi_q, hi_d;
  logic [15:0] cfg_q, cfg_d;
  logic        sda_oq, sda_od;
  logic        apply_q, apply_d;
  logic [15:0] result_q, result_d;
  logic [15:0] txw_q, txw_d;
  bmt_conv_t   cs_q, cs_d;
  logic        rdy_q, rdy_d;
  logic        tstart;
  logic [3:0]  tcode;
  logic        tbusy, tdone;

  function automatic logic addr_hit(input logic [6:0] a, input logic [1:0] sel);
    addr_hit = (a == bmt_pkg::BCAST_ADDR)
            || (a == (bmt_pkg::BASE_ADDR | {5'h0, sel}));
  endfunction

  function automatic logic [15:0] read_reg(input logic [7:0] p, input logic [15:0] c,
                                           input logic [15:0] r);
    if (p == bmt_pkg::REG_CONFIG) read_reg = c;
    else if (p == bmt_pkg::REG_RESULT) read_reg = r;
    else read_reg = 16'h0;
  endfunction

  always_comb begin
    st_d = st_q; sh_d = sh_q; bit_d = bit_q; byte_d = byte_q; rw_d = rw_q;
    ptr_d = ptr_q; hi_d = hi_q; cfg_d = cfg_q; sda_od = sda_oq;
    apply_d = 1'b0; txw_d = txw_q;
    if (start_c) begin
      st_d = ST_ADDR; bit_d = 4'h0; byte_d = 2'h0; sda_od = 1'b1;
    end else if (stop_c) begin
      st_d = ST_IDLE; sda_od = 1'b1;
    end else begin
      unique case (st_q)
        ST_IDLE, ST_SKIP: sda_od = 1'b1;
        ST_ADDR, ST_RX: begin
          if (scl_r) begin
            sh_d = {sh_q[6:0], sda_q[1]};
            bit_d = bit_q + 4'h1;
          end
          if (scl_f && bit_q == 4'h8) begin
            bit_d = 4'h0;
            if (st_q == ST_ADDR) begin
              if (addr_hit(sh_q[7:1], addr_sel)) begin
                rw_d = sh_q[0];
                st_d = ST_ACK;
                sda_od = 1'b0;
                txw_d = read_reg(ptr_q, cfg_q, result_q);
              end else begin
                st_d = ST_SKIP;
              end
            end else begin
              st_d = ST_ACK;
              sda_od = 1'b0;
              unique case (byte_q)
                2'h0: ptr_d = sh_q;
                2'h1: hi_d = sh_q;
                default: begin
                  if (ptr_q == bmt_pkg::REG_CONFIG) begin
                    cfg_d = {hi_q, sh_q};
                    apply_d = 1'b1;
                  end
                end
              endcase
              byte_d = (byte_q == 2'h2) ? 2'h1 : byte_q + 2'h1;
            end
          end
        end
        ST_ACK: if (scl_f) begin
          if (rw_q) begin
            st_d = ST_TX;
            sda_od = txw_q[15];
            txw_d = {txw_q[14:0], 1'b0};
            bit_d = 4'h1;
          end else begin
            st_d = ST_RX;
            sda_od = 1'b1;
          end
        end
        ST_TX: if (scl_f) begin
          if (bit_q == 4'h8) begin
            st_d = ST_TXACK; sda_od = 1'b1; bit_d = 4'h0;
          end else begin
            sda_od = txw_q[15];
            txw_d = {txw_q[14:0], 1'b0};
            bit_d = bit_q + 4'h1;
          end
        end
        ST_TXACK: begin
          if (scl_r && sda_q[1]) st_d = ST_SKIP;
          else if (scl_f) begin
            st_d = ST_TX;
            sda_od = txw_q[15];
            txw_d = {txw_q[14:0], 1'b0};
            bit_d = 4'h1;
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  // Single-shot sequencer: shunt conversion then bus conversion
  always_comb begin
    cs_d = cs_q; result_d = result_q; rdy_d = rdy_q; tstart = 1'b0;
    tcode = cfg_q[bmt_pkg::SCT_LSB +: 4];
    if (apply_q && cfg_q[bmt_pkg::MODE_LSB +: 3] == bmt_pkg::MODE_TRIG_BOTH) begin
      cs_d = CS_SHUNT; tstart = 1'b1; rdy_d = 1'b0;
    end else begin
      unique case (cs_q)
        CS_IDLE: ;
        CS_SHUNT: if (tdone) begin
          cs_d = CS_BUS; tstart = 1'b1;
          tcode = cfg_q[bmt_pkg::BCT_LSB +: 4];
          result_d = sample_shunt;
        end
        CS_BUS: begin
          tcode = cfg_q[bmt_pkg::BCT_LSB +: 4];
          if (tdone) begin
            cs_d = CS_IDLE; rdy_d = 1'b1; result_d = sample_bus;
          end
        end
        default: cs_d = CS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE; sh_q <= 8'h0; bit_q <= 4'h0; byte_q <= 2'h0;
      rw_q <= 1'b0; ptr_q <= 8'h0; hi_q <= 8'h0;
      cfg_q <= bmt_pkg::CONFIG_RESET; sda_oq <= 1'b1; apply_q <= 1'b0;
      txw_q <= 16'h0; cs_q <= CS_IDLE; result_q <= 16'h0; rdy_q <= 1'b0;
    end else begin
      st_q <= st_d; sh_q <= sh_d; bit_q <= bit_d; byte_q <= byte_d;
      rw_q <= rw_d; ptr_q <= ptr_d; hi_q <= hi_d;
      cfg_q <= cfg_d; sda_oq <= sda_od; apply_q <= apply_d;
      txw_q <= txw_d; cs_q <= cs_d; result_q <= result_d; rdy_q <= rdy_d;
    end
  end

  bmt_conv_timer #(.CYC3(CYC3), .CYCB(CYCB)) u_timer (
    .mclk  (mclk),
    .rst_b (rst_n),
    .start (tstart),
    .code  (tcode),
    .busy  (tbusy),
    .done  (tdone)
  );

  // fields pass straight out; code 0 means lowest range
  assign config_word  = cfg_q;
  assign conv_start   = tstart;
  assign conv_busy    = (cs_q != CS_IDLE) | tbusy;
  assign result_ready = rdy_q;
  assign sda_o  = 1'b0;
  assign sda_oe = ~sda_oq;

  a_trigger_start: assert property (@(posedge mclk) disable iff (!rst_n)
    (apply_q && cfg_q[bmt_pkg::MODE_LSB +: 3] == bmt_pkg::MODE_TRIG_BOTH) |-> conv_start)
    else $error("trigger did not start conversion");
  a_bcast_ack: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == ST_ADDR && scl_f && bit_q == 4'h8 && !start_c && !stop_c
     && sh_q[7:1] == bmt_pkg::BCAST_ADDR) |=> (st_q == ST_ACK && sda_oe))
    else $error("broadcast not acknowledged");
  a_conv_508: assert property (@(posedge mclk) disable iff (!rst_n)
    (tstart && tcode[1:0] == 2'h3) |=> (u_timer.cnt_q == 24'(CYC3)))
    else $error("code 3 time wrong");
  a_shot_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    (cs_q == CS_BUS && tdone && !apply_q) |=> (cs_q == CS_IDLE && result_ready))
    else $error("single shot did not idle");
  a_cfg_write: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(cfg_q) |-> apply_q)
    else $error("config changed without a write");

  // Shunt conversion end hands over to a fresh bus conversion
  sequence s_shunt_end;
    cs_q == CS_SHUNT && tdone && !apply_q;
  endsequence
  sequence s_bus_begin;
    conv_start ##1 (cs_q == CS_BUS && tbusy);
  endsequence
  a_bus_follows: assert property (@(posedge mclk) disable iff (!rst_n)
    s_shunt_end |-> s_bus_begin)
    else $error("bus conversion did not follow shunt");
endmodule

// ==== design/bmt_pkg.sv ====
/*
  Constants for the broadcast measurement trigger: I2C addresses, register
  indices, configuration field layout, conversion timing.
  Assumes a 100 MHz mclk and an I2C master on scl/sda.
*/
// Behaviour
// - Writes to broadcast address 0x7f are accepted regardless of own address.
// - Register 0 holds bus range, shunt gain range and operating mode.
// - Register 0 also holds separate bus and shunt conversion-time fields.
// - Zero bus range selects 16V; zero shunt gain selects 40mV.
// - Conversion-time code 3 gives a 508 us acquisition.
// - Mode 3 runs one acquisition of shunt and bus, then idles.
// - In mode 3, conversion starts as soon as the configuration write is applied.
package bmt_pkg;
  localparam logic [6:0]  BCAST_ADDR     = 7'h7f;
  localparam logic [6:0]  BASE_ADDR      = 7'h40;
  localparam logic [7:0]  REG_CONFIG     = 8'h00;
  localparam logic [7:0]  REG_RESULT     = 8'h03;
  localparam logic [15:0] CONFIG_RESET   = 16'h399f;
  localparam int          BUS_RANGE_LSB  = 13;
  localparam int          GAIN_LSB       = 11;
  localparam int          BCT_LSB        = 7;
  localparam int          SCT_LSB        = 3;
  localparam int          MODE_LSB       = 0;
  localparam logic [2:0]  MODE_TRIG_BOTH = 3'h3;
  localparam logic [1:0]  BUS_RANGE_16V  = 2'h0;
  localparam logic [1:0]  GAIN_40MV      = 2'h0;
  localparam int          CLK_MHZ        = 100;
  localparam int          T508_US        = 508;
  localparam int          CYC_508        = T508_US * CLK_MHZ;
  localparam int          CYC_BASE       = 72 * CLK_MHZ;
endpackage

// ==== design/bmt_conv_timer.sv ====
/*
  Conversion timer: counts the acquisition time of one channel.
  Assumes start is a one-cycle pulse on mclk.
*/
module bmt_conv_timer #(
  parameter int CYC3 = bmt_pkg::CYC_508,
  parameter int CYCB = bmt_pkg::CYC_BASE
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       start,
  input  wire logic [3:0] code,
  output logic            busy,
  output logic            done
);
  // Counts must be ordered and fit the 24-bit counter, doubled base included
  if (CYCB < 1 || CYC3 < CYCB || CYC3 >= 2 ** 24 || CYCB >= 2 ** 23) begin : g_bad_counts
    $error("bad timer counts");
  end
  logic [23:0] cnt_q, cnt_d;
  logic        done_q, done_d;
  function automatic logic [23:0] cycles(input logic [3:0] c);
    unique case (c[1:0])
      2'h3:    cycles = 24'(CYC3);
      2'h2:    cycles = 24'(CYCB * 2);
      2'h1:    cycles = 24'(CYCB);
      default: cycles = 24'(CYCB / 2 + 1);
    endcase
  endfunction
  always_comb begin
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (start) begin
      cnt_d = cycles(code);
    end else if (cnt_q != 24'h0) begin
      cnt_d = cnt_q - 24'h1;
      done_d = (cnt_q == 24'h1);
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q  <= 24'h0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end
  assign busy = (cnt_q != 24'h0);
  assign done = done_q;
endmodule

// ==== sim/bmt_host.sv ====
/*
  Host model: I2C master with a 125 ns serial clock that stands still between frames.
  Assumes a pull-up on sda that the bench resolves from every driver.
*/
module bmt_host (
  output logic        scl,
  output logic        sda_low,
  input  wire logic   sda,
  output logic        obs_v,
  output logic [15:0] obs_d
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam realtime Q = 31.25;
  initial begin
    scl = 1;
    sda_low = 0;
    obs_v = 0;
    obs_d = 0;
  end
  // Hands each acknowledge or read word to the bench monitor
  task automatic note(input logic [15:0] d);
    obs_d = d;
    #1 obs_v = 1;
    #1 obs_v = 0;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #Q scl = 1;
    #Q r = sda;
    #Q scl = 0;
    #Q;
  endtask
  // Works from idle and as a repeated start
  task automatic start;
    sda_low = 0;
    #Q scl = 1;
    #Q sda_low = 1;
    #Q scl = 0;
    #Q;
  endtask
  task automatic stop;
    sda_low = 1;
    #Q scl = 1;
    #Q sda_low = 0;
    #Q;
  endtask
  task automatic wr(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    note({15'h0000, r});
  endtask
  // Reads one word, high byte first, and refuses more after the low byte
  task automatic rd;
    logic [15:0] w;
    logic        r;
    for (int i = 15; i >= 0; i--) begin
      bit_io(1'b1, w[i]);
      if (i % 8 == 0) bit_io(i == 0, r);
    end
    note(w);
  endtask
endmodule

// ==== sim/test_broadcast_measurement_trigger.sv ====
/*
  Self-checking bench for bmt_top driven by the bmt_host model.
  Assumes short conversion counts set at the instance below.
*/
module test_broadcast_measurement_trigger;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          C3   = 40;
  localparam logic [15:0] TRIG = 16'h019b;
  logic        mclk = 0, rst_b = 0;
  logic [1:0]  addr_sel = 2'h0;
  logic [15:0] sample_bus = 16'h0000, sample_shunt = 16'h0000;
  logic        sda_o, sda_oe, conv_start, conv_busy, result_ready;
  logic [15:0] config_word, v;
  logic [15:0] expq[$];
  wire logic        scl, sda_low, obs_v;
  wire logic [15:0] obs_d;
  wire logic        sda = !(sda_low || (sda_oe && !sda_o));
  wire logic [6:0]  own = bmt_pkg::BASE_ADDR | {5'h00, addr_sel};
  int err_total = 0, checks = 0, seed, starts = 0, span = 0, s0, p0;

  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    starts <= starts + 32'(conv_start);
    span <= conv_busy ? span + 1 : span;
  end

  bmt_top #(.CYC3(C3), .CYCB(10)) dut (
    .mclk(mclk), .rst_b(rst_b), .addr_sel(addr_sel), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .sample_bus(sample_bus), .sample_shunt(sample_shunt),
    .config_word(config_word), .conv_start(conv_start), .conv_busy(conv_busy),
    .result_ready(result_ready));
  bmt_host u_host (.scl(scl), .sda_low(sda_low), .sda(sda), .obs_v(obs_v), .obs_d(obs_d));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Expected acknowledge per byte: 0 taken, 1 refused
  task automatic wreg(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
                      input logic two, input logic [15:0] ak);
    u_host.start();
    expq.push_back(ak);
    u_host.wr({a, 1'b0});
    expq.push_back(ak);
    u_host.wr(p);
    if (two) begin
      expq.push_back(ak);
      u_host.wr(d[15:8]);
      expq.push_back(ak);
      u_host.wr(d[7:0]);
    end
    u_host.stop();
  endtask
  task automatic rreg(input logic [6:0] a, input logic [7:0] p, input logic [15:0] exp);
    wreg(a, p, 16'h0000, 1'b0, 16'h0000);
    u_host.start();
    expq.push_back(16'h0000);
    u_host.wr({a, 1'b1});
    expq.push_back(exp);
    u_host.rd();
    u_host.stop();
  endtask

  always @(posedge obs_v) check(obs_d, expq.pop_front());

  initial begin
    seed = 551;
    repeat (16) @(negedge mclk);
    rst_b = 1;
    repeat (4) @(negedge mclk);
    rreg(own, 8'h00, bmt_pkg::CONFIG_RESET);
    v = 16'($random(seed));
    v[2:0] = 3'h5;
    s0 = starts;
    wreg(own, 8'h00, v, 1'b1, 16'h0000);
    wreg(own, 8'h03, ~v, 1'b1, 16'h0000);
    rreg(own, 8'h00, v);
    check(16'(starts - s0), 16'h0000);
    for (int k = 0; k < 4; k++) begin
      @(negedge mclk);
      addr_sel = 2'(k);
      sample_bus = 16'($random(seed));
      sample_shunt = 16'($random(seed));
      s0 = starts;
      p0 = span;
      wreg(bmt_pkg::BCAST_ADDR, 8'h00, TRIG, 1'b1, 16'h0000);
      check(conv_busy, 16'h0001);
      check(config_word, TRIG);
      check({config_word[bmt_pkg::BUS_RANGE_LSB +: 2], config_word[bmt_pkg::GAIN_LSB +: 2]},
            {bmt_pkg::BUS_RANGE_16V, bmt_pkg::GAIN_40MV});
      check({config_word[10:7], config_word[6:3]}, 16'h0033);
      for (int i = 0; i < 300 && result_ready !== 1'b1; i++) @(negedge mclk);
      check(result_ready, 16'h0001);
      repeat (50) @(negedge mclk);
      check(conv_busy, 16'h0000);
      check(16'(starts - s0), 16'h0002);
      check(16'(span - p0 >= 2 * C3 && span - p0 <= 2 * C3 + 4), 16'h0001);
      rreg(own, 8'h03, sample_bus);
      wreg(own ^ 7'h01, 8'h00, 16'h0000, 1'b1, 16'h0001);
      check(config_word, TRIG);
    end
    repeat (20) @(negedge mclk);
    final_report();
  end

  initial begin
    #500us;
    err_total++;
    final_report();
  end
endmodule
